// ### src/dmba_addr_gen.sv
// dmba_addr_gen: program counter, data bank selection, stack saves
// Assumes the core drives one request per cycle and a memory that
// answers a read in the same cycle the command is shown
//
// Contract
// - Program counter holds twelve bits
// - Program space is 4096 bytes, separate
// - Fetch begins at address zero after reset
// - Zero-page calls land in 10H to 1FH
// - Interrupt vectors sit at 020H to 03DH
// - Data is nibbles, 256 per bank
// - Address is bank bits plus nibble offset
// - Special registers sit at or below 07FH, bank 0
// - Pointer one uses primary; pointer two and direct follow enable
// - Common flag sends low direct to bank 0
// - Stack accesses always hit bank seven
// - Odd select means bank 7, even 0
// - Bank state saved and restored as one
// - Stack counter decrements on push, increments pop
// - Reset loads stack pointer with 0FFH
// - Stack pointer reachable only by byte access
// - Stack pointer end bits fixed at one
// - Stack transfers are always whole bytes
// - Interrupt entry pushes accumulator, pointer, carry
// - Carry takes add carry and subtract borrow
// - Stack pointer lives at 7EH-7FH, bank 0
// - Reset clears bank selects and both flags
`timescale 1ns/1ps
`include "dmba_defs.svh"

module dmba_addr_gen
(
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rst_in,
  // Program counter control
  input  wire dmba_pkg::dmba_pc_op_t     pc_op_in,
  input  wire logic [11:0]               pc_target_in,
  input  wire logic [2:0]                zp_index_in,
  input  wire logic [3:0]                irq_vec_in,
  output logic      [11:0]               pc_out,
  // Register views from the core
  input  wire dmba_pkg::dmba_nib_pair_t  acc_pair_in,
  input  wire dmba_pkg::dmba_nib_pair_t  ptr1_in,
  input  wire dmba_pkg::dmba_nib_pair_t  ptr2_in,
  // Arithmetic result flags
  input  wire logic                      add_in,
  input  wire logic                      sub_in,
  input  wire logic                      alu_carry_in,
  output logic                           carry_out,
  // Core data access
  input  wire logic                      req_valid_in,
  input  wire dmba_pkg::dmba_mem_req_t   req_in,
  // Bank state control
  input  wire logic                      bank_wr_in,
  input  wire dmba_pkg::dmba_bank_state_t bank_wdata_in,
  input  wire logic                      save_bank_in,
  input  wire logic                      restore_bank_in,
  output dmba_pkg::dmba_bank_state_t     bank_out,
  // Interrupt entry
  input  wire logic                      irq_entry_in,
  output logic                           busy_out,
  // Memory side
  output dmba_pkg::dmba_mem_cmd_t        mem_out,
  input  wire logic [7:0]                mem_rdata_in,
  // Stack pointer read back
  output logic      [7:0]                rd_data_out,
  output logic                           rd_valid_out,
  output logic      [7:0]                sp_out
);
  import dmba_pkg::*;

  // =====================================================================
  // State
  dmba_irq_state_t  irq_st_r;
  dmba_irq_state_t  irq_st_nxt;
  logic [11:0]      pc_r;
  logic [11:0]      pc_nxt;
  logic             carry_r;
  logic             carry_nxt;
  dmba_bank_state_t bank_r;
  dmba_bank_state_t bank_nxt;
  logic             restore_pend_r;
  dmba_mem_cmd_t    mem_r;
  dmba_mem_cmd_t    mem_nxt;
  logic [7:0]       rd_data_r;
  logic             rd_valid_r;
  logic [7:0]       sp_val;

  // Even select picks bank 0, odd picks bank 7
  function automatic logic [2:0] map_bank(input logic [2:0] bsr);
    map_bank = bsr[0] ? `DMBA_BANK_STACK : `DMBA_BANK_COMMON;
  endfunction : map_bank

  // =====================================================================
  // Program counter
  logic [11:0] zp_addr;
  logic [3:0]  vec_idx;
  logic [11:0] vec_addr;

  // Two bytes per entry point, eight entries in 10H..1FH
  assign zp_addr  = `DMBA_ZP_BASE + {8'h00, zp_index_in, 1'b0};
  // Clamp keeps an out-of-range index inside the vector area
  assign vec_idx  = (irq_vec_in > `DMBA_IV_MAX) ? `DMBA_IV_MAX
                                                 : irq_vec_in;
  assign vec_addr = `DMBA_IV_BASE + {7'h00, vec_idx, 1'b0};

  // Twelve-bit add wraps inside the 4K program space
  assign pc_nxt =
    (pc_op_in == DMBA_PC_NEXT)   ? pc_r + 12'h001 :
    (pc_op_in == DMBA_PC_JUMP)   ? pc_target_in :
    (pc_op_in == DMBA_PC_ZPCALL) ? zp_addr :
    (pc_op_in == DMBA_PC_VECTOR) ? vec_addr :
                                   pc_r;

  // Program counter register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      pc_r <= `DMBA_PC_RST;
    else
      pc_r <= pc_nxt;
  end

  assign pc_out = pc_r;

  // =====================================================================
  // Carry flag
  assign carry_nxt = (add_in || sub_in) ? alu_carry_in : carry_r;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      carry_r <= `DMBA_CARRY_RST;
    else
      carry_r <= carry_nxt;
  end

  assign carry_out = carry_r;

  // =====================================================================
  // Interrupt entry save sequence
  logic       irq_busy;
  logic [7:0] irq_byte;

  assign irq_busy = (irq_st_r != IRQ_IDLE);

  // One push per state; carry travels in bit 0 of its own byte
  always_comb
  begin
    irq_st_nxt = irq_st_r;
    irq_byte   = 8'h00;
    unique case (irq_st_r)
      IRQ_IDLE:
      begin
        if (irq_entry_in)
          irq_st_nxt = IRQ_ACC;
      end
      IRQ_ACC:
      begin
        irq_byte   = acc_pair_in;
        irq_st_nxt = IRQ_PTR;
      end
      IRQ_PTR:
      begin
        irq_byte   = ptr1_in;
        irq_st_nxt = IRQ_CARRY;
      end
      IRQ_CARRY:
      begin
        irq_byte   = {7'h00, carry_r};
        irq_st_nxt = IRQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_st_r <= IRQ_IDLE;
    else
      irq_st_r <= irq_st_nxt;
  end

  assign busy_out = irq_busy;

  // =====================================================================
  // Request selection: save sequence, then bank push/pop, then core
  logic       bank_sel;
  logic       core_sel;
  logic       eff_valid;
  dmba_mode_t eff_mode;
  logic       eff_wr;
  logic       eff_byte;
  logic [7:0] eff_wdata;

  assign bank_sel  = !irq_busy && (save_bank_in || restore_bank_in);
  assign core_sel  = req_valid_in && !irq_busy && !save_bank_in
                     && !restore_bank_in;
  assign eff_valid = irq_busy || bank_sel || core_sel;
  assign eff_mode  = (irq_busy || bank_sel) ? DMBA_MODE_STACK
                                            : req_in.mode;
  assign eff_wr    = irq_busy ? 1'b1 :
                     bank_sel ? save_bank_in : req_in.wr;
  // Stack traffic is always a nibble pair
  assign eff_byte  = (eff_mode == DMBA_MODE_STACK) || req_in.byte_wide;
  // Bank state is pushed as one byte
  assign eff_wdata = irq_busy ? irq_byte :
                     bank_sel ? bank_r : req_in.wdata;

  // =====================================================================
  // Bank and offset decode
  logic [2:0] bank_pri;
  logic [2:0] bank_sec;
  logic [2:0] bank_alt;
  logic       direct_common;
  logic [2:0] eff_bank;
  logic [7:0] sp_pop_addr;
  logic [7:0] eff_low;

  assign bank_pri = map_bank(bank_r.bank_select_primary);
  assign bank_sec = map_bank(bank_r.bank_select_secondary);
  assign bank_alt = bank_r.bef ? bank_sec : bank_pri;
  assign direct_common = bank_r.bcf && !req_in.operand[7];

  assign eff_bank =
    (eff_mode == DMBA_MODE_STACK) ? `DMBA_BANK_STACK :
    (eff_mode == DMBA_MODE_PTR1)  ? bank_pri :
    (eff_mode == DMBA_MODE_PTR2)  ? bank_alt :
    direct_common                 ? `DMBA_BANK_COMMON :
                                    bank_alt;

  // Pop reads the pair above the current pointer
  assign sp_pop_addr = {1'b1, sp_val[6:1] + 6'h01, 1'b1};

  // First register of a pair is the high nibble
  assign eff_low =
    (eff_mode == DMBA_MODE_PTR1)  ? {ptr1_in.hi, ptr1_in.lo} :
    (eff_mode == DMBA_MODE_PTR2)  ? {ptr2_in.hi, ptr2_in.lo} :
    (eff_mode == DMBA_MODE_DIRECT) ? req_in.operand :
    eff_wr                        ? sp_val : sp_pop_addr;

  // =====================================================================
  // Stack pointer location in the special register area
  logic sp_hit;
  logic sp_byte_wr;
  logic sp_byte_rd;
  logic sp_push;
  logic sp_pop;

  // Any direct-mode access to 7EH/7FH of bank 0 is captured here, never passed on;
  // it is the top pair of the special register area
  assign sp_hit = core_sel && (req_in.mode == DMBA_MODE_DIRECT)
                  && (eff_bank == `DMBA_BANK_COMMON)
                  && ({req_in.operand[7:1], 1'b0} == `DMBA_SP_OFS);
  // Nibble accesses see nothing: no write, and no read answer
  assign sp_byte_wr = sp_hit && req_in.byte_wide && req_in.wr;
  assign sp_byte_rd = sp_hit && req_in.byte_wide && !req_in.wr;
  assign sp_push = eff_valid && (eff_mode == DMBA_MODE_STACK) && eff_wr;
  assign sp_pop  = eff_valid && (eff_mode == DMBA_MODE_STACK) && !eff_wr;

  dmba_stack_ptr u_sp
  (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .push_in  (sp_push),
    .pop_in   (sp_pop),
    .wr_in    (sp_byte_wr),
    .wdata_in (req_in.wdata),
    .sp_out   (sp_val)
  );

  assign sp_out = sp_val;

  // =====================================================================
  // Memory command, registered so the memory sees clean levels
  assign mem_nxt = '{
    en:        eff_valid && !sp_hit,
    we:        eff_wr,
    byte_wide: eff_byte,
    addr:      {eff_bank, eff_low},
    wdata:     eff_wdata
  };

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      mem_r <= '0;
    else
      mem_r <= mem_nxt;
  end

  assign mem_out = mem_r;

  // Stack pointer read answer; end bits always read as one
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_data_r  <= sp_byte_rd ? sp_val : 8'h00;
      rd_valid_r <= sp_byte_rd;
    end
  end

  assign rd_data_out  = rd_data_r;
  assign rd_valid_out = rd_valid_r;

  // =====================================================================
  // Bank state: restore lands when the popped byte comes back
  assign bank_nxt = restore_pend_r ? dmba_bank_state_t'(mem_rdata_in) :
                    bank_wr_in     ? bank_wdata_in : bank_r;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bank_r         <= '{bcf: `DMBA_FLAG_RST, bank_select_secondary: `DMBA_BSR_RST,
                          bef: `DMBA_FLAG_RST, bank_select_primary: `DMBA_BSR_RST};
      restore_pend_r <= 1'b0;
    end
    else
    begin
      bank_r         <= bank_nxt;
      restore_pend_r <= bank_sel && restore_bank_in;
    end
  end

  assign bank_out = bank_r;

  // =====================================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  pc_reset_zero_a: assert property (
    $fell(rst_in) |-> pc_out == 12'h000)
    else $error("fetch does not start at zero");
  pc_zp_call_a: assert property (
    pc_op_in == DMBA_PC_ZPCALL |=> pc_out >= 12'h010
      && pc_out <= 12'h01e && !pc_out[0])
    else $error("zero-page call outside entry area");
  pc_vector_a: assert property (
    pc_op_in == DMBA_PC_VECTOR |=> pc_out >= 12'h020
      && pc_out <= 12'h03d)
    else $error("vector outside interrupt area");
  pc_next_wrap_a: assert property (
    pc_op_in == DMBA_PC_NEXT |=> pc_out == $past(pc_out) + 12'h001)
    else $error("program counter step wrong");
  carry_load_a: assert property (
    add_in || sub_in |=> carry_out == $past(alu_carry_in))
    else $error("carry not loaded from arithmetic");
  irq_push_seq_a: assert property (
    irq_entry_in && !irq_busy |=> ##1
      (mem_out.en && mem_out.we && mem_out.wdata == $past(acc_pair_in))
      ##1 (mem_out.en && mem_out.addr[10:8] == 3'h7)
      ##1 (mem_out.en && mem_out.wdata[7:1] == 7'h00) ##1 !busy_out)
    else $error("interrupt save sequence wrong");
  stack_bank_a: assert property (
    sp_push || sp_pop |=> mem_out.addr[10:8] == 3'h7
      && mem_out.byte_wide)
    else $error("stack access outside bank seven");
  ptr1_bank_a: assert property (
    core_sel && req_in.mode == DMBA_MODE_PTR1
      |=> mem_out.addr[10:8] == {3{$past(bank_r.bank_select_primary[0])}})
    else $error("pointer one used wrong bank");
  common_bank_a: assert property (
    core_sel && req_in.mode == DMBA_MODE_DIRECT && bank_r.bcf
      && !req_in.operand[7] |=> mem_out.addr[10:8] == 3'h0)
    else $error("common area not forced to bank 0");
  bank_restore_a: assert property (
    bank_sel && restore_bank_in |-> ##2
      bank_out == dmba_bank_state_t'($past(mem_rdata_in)))
    else $error("bank state not restored");
  sp_read_a: assert property (
    sp_byte_rd |=> rd_valid_out && rd_data_out[7] && rd_data_out[0]
      && !mem_out.en)
    else $error("stack pointer read wrong");

  irq_seq_c: cover property (irq_entry_in && !irq_busy ##4 !busy_out);
  restore_c: cover property (bank_sel && restore_bank_in ##2 1'b1);
  sp_read_c: cover property (sp_byte_rd);
  common_c:  cover property (core_sel && direct_common
                             && req_in.mode == DMBA_MODE_DIRECT);

endmodule : dmba_addr_gen

// ### src/dmba_defs.svh
// dmba_defs.svh: address map, reset values and fixed bank numbers
// Assumes inclusion by bare name from the two design files
`ifndef DMBA_DEFS_SVH
`define DMBA_DEFS_SVH

// =====================================================================
// Program memory map
`define DMBA_PC_RST      12'h000
`define DMBA_ZP_BASE     12'h010
`define DMBA_IV_BASE     12'h020
`define DMBA_IV_LAST     12'h03d
`define DMBA_IV_MAX      4'he
`define DMBA_TEST_BASE   12'hfe0

// =====================================================================
// Data memory map
`define DMBA_SFR_TOP     8'h7f
`define DMBA_SP_OFS      8'h7e
`define DMBA_SP_RST      8'hff
`define DMBA_SP_CNT_RST  6'h3f
`define DMBA_SP_FIXED    1'h1
`define DMBA_BANK_COMMON 3'h0
`define DMBA_BANK_STACK  3'h7
`define DMBA_BSR_RST     3'h0
`define DMBA_FLAG_RST    1'h0
`define DMBA_CARRY_RST   1'h0

`endif

// ### src/dmba_pkg.sv
// dmba_pkg: types shared by the address generator and stack pointer
// Assumes constants come from dmba_defs.svh
package dmba_pkg;

  // ===================================================================
  // Modes and operations
  typedef enum logic [1:0] {
    DMBA_MODE_PTR1, DMBA_MODE_PTR2, DMBA_MODE_DIRECT, DMBA_MODE_STACK
  } dmba_mode_t;

  typedef enum logic [2:0] {
    DMBA_PC_HOLD, DMBA_PC_NEXT, DMBA_PC_JUMP, DMBA_PC_ZPCALL,
    DMBA_PC_VECTOR
  } dmba_pc_op_t;

  typedef enum logic [1:0] {
    IRQ_IDLE, IRQ_ACC, IRQ_PTR, IRQ_CARRY
  } dmba_irq_state_t;

  // ===================================================================
  // Carriers
  typedef struct packed {
    logic [3:0] hi;
    logic [3:0] lo;
  } dmba_nib_pair_t;

  typedef struct packed {
    logic       bcf;
    logic [2:0] bank_select_secondary;
    logic       bef;
    logic [2:0] bank_select_primary;
  } dmba_bank_state_t;

  typedef struct packed {
    dmba_mode_t mode;
    logic [7:0] operand;
    logic       wr;
    logic       byte_wide;
    logic [7:0] wdata;
  } dmba_mem_req_t;

  typedef struct packed {
    logic        en;
    logic        we;
    logic        byte_wide;
    logic [10:0] addr;
    logic [7:0]  wdata;
  } dmba_mem_cmd_t;

endpackage : dmba_pkg

// ### src/dmba_stack_ptr.sv
// dmba_stack_ptr: stack pointer with fixed end bits and 6-bit counter
// Assumes push, pop and write are never raised together
`timescale 1ns/1ps
`include "dmba_defs.svh"

module dmba_stack_ptr
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Stack motion
  input  wire logic       push_in,
  input  wire logic       pop_in,
  // Byte write
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  // Value
  output logic      [7:0] sp_out
);
  import dmba_pkg::*;

  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;

  // =====================================================================
  // Counter: write keeps only the middle bits
  assign cnt_nxt = wr_in   ? wdata_in[6:1] :
                   push_in ? cnt_r - 6'h1 :
                   pop_in  ? cnt_r + 6'h1 :
                             cnt_r;

  // End bits are wired, so no write can disturb them
  assign sp_out = {`DMBA_SP_FIXED, cnt_r, `DMBA_SP_FIXED};

  // Counter register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      cnt_r <= `DMBA_SP_CNT_RST;
    else
      cnt_r <= cnt_nxt;
  end

  // =====================================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sp_push_dec_a: assert property (
    push_in && !wr_in |=> cnt_r == $past(cnt_r) - 6'h1)
    else $error("push did not decrement stack pointer");
  sp_pop_inc_a: assert property (
    pop_in && !wr_in && !push_in |=> cnt_r == $past(cnt_r) + 6'h1)
    else $error("pop did not increment stack pointer");
  sp_write_mid_a: assert property (
    wr_in |=> sp_out == {1'b1, $past(wdata_in[6:1]), 1'b1})
    else $error("stack pointer write kept wrong bits");
  sp_reset_value_a: assert property (
    $fell(rst_in) |-> sp_out == `DMBA_SP_RST)
    else $error("stack pointer reset value wrong");

endmodule : dmba_stack_ptr

// ### test/data_memory_bank_addressing_tb.sv
// data_memory_bank_addressing_tb: self-checking bench for dmba_addr_gen
// Assumes dmba_pkg is compiled first; memory read data driven directly
`timescale 1ns/1ps

module data_memory_bank_addressing_tb;
  import dmba_pkg::*;

  // ===================================================================
  // Signals
  logic             clk_in = 1'b0;
  logic             rst_in = 1'b1;
  dmba_pc_op_t      pc_op = DMBA_PC_HOLD;
  logic [11:0]      pc_tgt = 12'h000;
  logic [2:0]       zp_idx = 3'h0;
  logic [3:0]       vec = 4'h0;
  logic [11:0]      pc;
  dmba_nib_pair_t   acc = 8'h00;
  dmba_nib_pair_t   p1 = 8'h00;
  dmba_nib_pair_t   p2 = 8'h00;
  logic             add = 1'b0;
  logic             sub = 1'b0;
  logic             alu_c = 1'b0;
  logic             carry;
  logic             rv = 1'b0;
  dmba_mem_req_t    rq = '0;
  logic             bwr = 1'b0;
  dmba_bank_state_t bwd = 8'h00;
  logic             save = 1'b0;
  logic             rest = 1'b0;
  dmba_bank_state_t bank;
  logic             irq = 1'b0;
  logic             busy;
  dmba_mem_cmd_t    mem;
  logic [7:0]       rdat = 8'h00;
  logic [7:0]       rd;
  logic             rd_v;
  logic [7:0]       sp;
  int               fail_count = 0;
  int               n_checks = 0;

  typedef struct {
    logic [7:0]  bk;
    dmba_mode_t  md;
    logic [7:0]  p;
    logic [10:0] a;
  } dmba_row_t;

  // Bank byte is {bcf,bank_select_secondary,bef,bank_select_primary}; pointers and operand share p
  dmba_row_t rows [12] = '{
    '{8'h00, DMBA_MODE_PTR1, 8'h3c, 11'h03c},
    '{8'h01, DMBA_MODE_PTR1, 8'ha5, 11'h7a5},
    '{8'h05, DMBA_MODE_PTR1, 8'h01, 11'h701},
    '{8'h04, DMBA_MODE_PTR1, 8'h02, 11'h002},
    '{8'h07, DMBA_MODE_DIRECT, 8'h03, 11'h703},
    '{8'h18, DMBA_MODE_PTR1, 8'h12, 11'h012},
    '{8'h18, DMBA_MODE_PTR2, 8'h34, 11'h734},
    '{8'h18, DMBA_MODE_DIRECT, 8'h56, 11'h756},
    '{8'h10, DMBA_MODE_PTR2, 8'h34, 11'h034},
    '{8'h98, DMBA_MODE_DIRECT, 8'h56, 11'h056},
    '{8'h98, DMBA_MODE_DIRECT, 8'h80, 11'h780},
    '{8'h83, DMBA_MODE_DIRECT, 8'h90, 11'h790}
  };

  dmba_addr_gen i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .pc_op_in(pc_op),
    .pc_target_in(pc_tgt), .zp_index_in(zp_idx), .irq_vec_in(vec),
    .pc_out(pc), .acc_pair_in(acc), .ptr1_in(p1), .ptr2_in(p2),
    .add_in(add), .sub_in(sub), .alu_carry_in(alu_c),
    .carry_out(carry), .req_valid_in(rv), .req_in(rq),
    .bank_wr_in(bwr), .bank_wdata_in(bwd), .save_bank_in(save),
    .restore_bank_in(rest), .bank_out(bank), .irq_entry_in(irq),
    .busy_out(busy), .mem_out(mem), .mem_rdata_in(rdat),
    .rd_data_out(rd), .rd_valid_out(rd_v), .sp_out(sp)
  );

  // ===================================================================
  // Clock and helpers
  always #5 clk_in = ~clk_in;

  // Inputs change 1 ns after the rising edge, outputs read there too
  task automatic step();
    @(posedge clk_in);
    #1;
  endtask : step

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic end_of_test();
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task automatic pc_do(input dmba_pc_op_t op, input logic [11:0] t,
                       input logic [2:0] z, input logic [3:0] v,
                       input logic [11:0] e);
    pc_op = op; pc_tgt = t; zp_idx = z; vec = v;
    @(posedge clk_in);
    pc_op <= DMBA_PC_HOLD;
    #1;
    chk("pc", 16'(e), 16'(pc));
  endtask : pc_do

  task automatic set_bank(input logic [7:0] b);
    bwr = 1'b1;
    bwd = b;
    step();
    bwr = 1'b0;
  endtask : set_bank

  // One request, taken at the next edge; mem_out is read right after
  task automatic req(input dmba_mode_t m, input logic [7:0] o,
                     input logic w, bw, input logic [7:0] d);
    rv = 1'b1;
    rq = '{m, o, w, bw, d};
    p1 = o;
    p2 = o;
    @(posedge clk_in);
    rv <= 1'b0;
    #1;
  endtask : req

  // Checks a memory command: enable, write, address, data on writes
  task automatic chk_mem(input logic w, input logic [10:0] a,
                         input logic [7:0] d);
    chk("mem.en", 16'h1, 16'(mem.en));
    chk("mem.we", 16'(w), 16'(mem.we));
    chk("mem.addr", 16'(a), 16'(mem.addr));
    if (w)
      chk("mem.wdata", 16'(d), 16'(mem.wdata));
  endtask : chk_mem

  task automatic chk_reset();
    chk("pc", 16'h000, 16'(pc));
    chk("sp", 16'h0ff, 16'(sp));
    chk("bank", 16'h000, 16'(bank));
    chk("carry", 16'h0, 16'(carry));
  endtask : chk_reset

  // ===================================================================
  // Watchdog: a hang counts as a mismatch
  initial
  begin
    #500_000;
    fail_count++;
    end_of_test();
  end

  // ===================================================================
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_in);
    #1;
    chk_reset();
    rst_in = 1'b0;
    step();
    chk_reset();
    // Program counter sequencing
    pc_do(DMBA_PC_NEXT, 12'h000, 3'h0, 4'h0, 12'h001);
    // Fetches stay below the reserved test area
    pc_do(DMBA_PC_JUMP, 12'hfde, 3'h0, 4'h0, 12'hfde);
    pc_do(DMBA_PC_NEXT, 12'h000, 3'h0, 4'h0, 12'hfdf);
    pc_do(DMBA_PC_ZPCALL, 12'h000, 3'h0, 4'h0, 12'h010);
    pc_do(DMBA_PC_ZPCALL, 12'h000, 3'h7, 4'h0, 12'h01e);
    pc_do(DMBA_PC_VECTOR, 12'h000, 3'h0, 4'h0, 12'h020);
    pc_do(DMBA_PC_VECTOR, 12'h000, 3'h0, 4'hf, 12'h03c);
    // Carry: borrow then carry
    sub = 1'b1; alu_c = 1'b0;
    step();
    sub = 1'b0;
    chk("carry", 16'h0, 16'(carry));
    add = 1'b1; alu_c = 1'b1;
    step();
    add = 1'b0; alu_c = 1'b0;
    chk("carry", 16'h1, 16'(carry));
    // Bank selection table
    foreach (rows[i])
    begin
      set_bank(rows[i].bk);
      req(rows[i].md, rows[i].p, 1'b0, 1'b0, 8'h00);
      chk_mem(1'b0, rows[i].a, 8'h00);
    end
    // Push then pop, always bank 7, SP moves by a byte
    req(DMBA_MODE_STACK, 8'h00, 1'b1, 1'b1, 8'ha5);
    chk_mem(1'b1, 11'h7ff, 8'ha5);
    chk("mem.byte_wide", 16'h1, 16'(mem.byte_wide));
    chk("sp", 16'h0fd, 16'(sp));
    req(DMBA_MODE_STACK, 8'h00, 1'b0, 1'b1, 8'h00);
    chk_mem(1'b0, 11'h7ff, 8'h00);
    chk("sp", 16'h0ff, 16'(sp));
    // Bank state save and restore as one byte
    set_bank(8'hb5);
    save = 1'b1;
    step();
    save = 1'b0;
    chk_mem(1'b1, 11'h7ff, 8'hb5);
    rest = 1'b1;
    rdat = 8'h2a;
    step();
    rest = 1'b0;
    chk_mem(1'b0, 11'h7ff, 8'h00);
    step();
    chk("bank", 16'h02a, 16'(bank));
    // Interrupt entry saves three bytes
    acc = 8'h5a;
    p1 = 8'hc3;
    irq = 1'b1;
    step();
    irq = 1'b0;
    chk("busy", 16'h1, 16'(busy));
    step();
    chk_mem(1'b1, 11'h7ff, 8'h5a);
    step();
    chk_mem(1'b1, 11'h7fd, 8'hc3);
    step();
    chk_mem(1'b1, 11'h7fb, 8'h01);
    chk("busy", 16'h0, 16'(busy));
    chk("sp", 16'h0f9, 16'(sp));
    // Stack pointer as a bank-0 byte: fixed end bits, no memory cycle
    set_bank(8'h00);
    req(DMBA_MODE_DIRECT, 8'h7e, 1'b1, 1'b1, 8'h00);
    chk("mem.en", 16'h0, 16'(mem.en));
    step();
    chk("sp", 16'h081, 16'(sp));
    req(DMBA_MODE_DIRECT, 8'h7e, 1'b0, 1'b1, 8'h00);
    chk("rd_valid", 16'h1, 16'(rd_v));
    chk("rd_data", 16'h081, 16'(rd));
    req(DMBA_MODE_DIRECT, 8'h7f, 1'b1, 1'b0, 8'h66);
    chk("mem.en", 16'h0, 16'(mem.en));
    chk("rd_valid", 16'h0, 16'(rd_v));
    step();
    chk("sp", 16'h081, 16'(sp));
    // Second reset in mid-run
    rst_in = 1'b1;
    step();
    chk_reset();
    rst_in = 1'b0;
    step();
    end_of_test();
  end

endmodule : data_memory_bank_addressing_tb
